// [hdl/kse_top.sv]
// keyboard scan encoder: matrix scan, debounce, repeat, buffer and host code port
`timescale 1ns/1ps
module kse_top #(
    parameter int unsigned SLOT_CYCLES     = kse_pkg::KSE_SLOT_CYCLES,
    parameter int unsigned LINK_LOW_CYCLES = kse_pkg::KSE_LINK_LOW_CYCLES
) (
    input  wire logic        sys_clk,
    input  wire logic        reset,
    input  wire logic [7:0]  rowSense,
    output logic      [15:0] colDrive,
    input  wire logic        linkClk,
    input  wire logic [7:0]  ioAddr,
    input  wire logic        ioRd,
    input  wire logic        ioWr,
    input  wire logic [7:0]  ioWrData,
    output logic      [7:0]  ioRdData,
    input  wire logic [7:0]  boardSwitch,
    output logic      [7:0]  portBOut,
    output logic             keyIrq1,
    output logic             numLockLed,
    output logic             capsLockLed
);
    import kse_pkg::*;

    // =========================================================
    // state
    typedef struct packed {
        kse_phase_t  phase;
        logic [21:0] linkLowCnt;
        logic        linkS1;
        logic        linkS2;
        logic        linkS3;
        logic        linkLevel;
        logic [7:0]  rowS1;
        logic [7:0]  rowS2;
        logic [7:0]  rowS3;
        logic [7:0]  rowStable;
        logic [7:0]  swS1;
        logic [7:0]  swS2;
        logic [7:0]  swS3;
        logic [7:0]  swStable;
        logic [12:0] slotCnt;
        logic [6:0]  pos;
        logic [15:0] colDrive;
        logic        pushValid;
        logic [7:0]  pushData;
        logic        secondPend;
        logic [7:0]  codeLatch;
        logic        latchFull;
        logic        irq;
        logic [7:0]  portB;
        logic [7:0]  rdData;
        logic        ledNum;
        logic        ledCaps;
    } kse_state_t;

    kse_state_t      s;
    kse_state_t      next_s;
    kse_key_t        keyMem [KSE_NUM_KEYS];
    kse_key_t        entry;
    kse_key_t        memData;
    logic            memWe;
    logic            fifoRdValid;
    logic [7:0]      fifoRdData;
    logic            slotEnd;
    logic            hit;
    logic            isNum;
    logic [6:0]      cntInc;
    logic            ackWrite;

    // a bit changes only once the second and third stages agree
    function automatic logic [7:0] agreeUpdate(input logic [7:0] s2,
                                               input logic [7:0] s3,
                                               input logic [7:0] old);
        agreeUpdate = (s2 & ~(s2 ^ s3)) | (old & (s2 ^ s3));
    endfunction

    function automatic logic [15:0] colStrobe(input logic [6:0] p);
        colStrobe = 16'h0001 << p[6:3];
    endfunction

    assign entry    = keyMem[s.pos];
    assign slotEnd  = (s.phase == KSE_P_SCAN) && (s.slotCnt == 13'(SLOT_CYCLES - 1));
    assign hit      = s.rowStable[s.pos[2:0]];
    assign isNum    = {1'b0, s.pos} == KSE_CODE_NUM_MAKE;
    assign cntInc   = entry.cnt + 7'h01;
    assign ackWrite = ioWr && (ioAddr == KSE_ADDR_PORT_B) && ioWrData[KSE_PORTB_ACK_BIT];

    // =========================================================
    // next state
    always_comb begin
        next_s           = s;
        memWe            = 1'b0;
        memData          = '0;
        next_s.pushValid = 1'b0;
        // input synchronisers
        next_s.linkS1    = linkClk;
        next_s.linkS2    = s.linkS1;
        next_s.linkS3    = s.linkS2;
        next_s.linkLevel = agreeUpdate({7'h00, s.linkS2}, {7'h00, s.linkS3},
                                       {7'h00, s.linkLevel}) != 8'h00;
        next_s.rowS1     = rowSense;
        next_s.rowS2     = s.rowS1;
        next_s.rowS3     = s.rowS2;
        next_s.rowStable = agreeUpdate(s.rowS2, s.rowS3, s.rowStable);
        next_s.swS1      = boardSwitch;
        next_s.swS2      = s.swS1;
        next_s.swS3      = s.swS2;
        next_s.swStable  = agreeUpdate(s.swS2, s.swS3, s.swStable);

        case (s.phase)
            KSE_P_INIT: begin
                // RAM self-test: every key slot is written clean once
                memWe      = 1'b1;
                next_s.pos = s.pos + 7'h01;
                if (s.pos == 7'(KSE_NUM_KEYS - 1)) begin
                    next_s.phase = KSE_P_LINK;
                end
            end
            KSE_P_LINK: begin
                if (s.linkLevel) begin
                    next_s.linkLowCnt = '0;
                end else begin
                    next_s.linkLowCnt = s.linkLowCnt + 22'h000001;
                end
                if (s.linkLowCnt == 22'(LINK_LOW_CYCLES - 1)) begin
                    next_s.pushValid = 1'b1;
                    next_s.pushData  = KSE_CODE_SELFTEST;
                    next_s.phase     = KSE_P_SCAN;
                end
            end
            KSE_P_SCAN: begin
                next_s.slotCnt = slotEnd ? 13'h0000 : s.slotCnt + 13'h0001;
                if (s.secondPend) begin
                    next_s.pushValid  = 1'b1;
                    next_s.pushData   = KSE_CODE_NUM_BREAK;
                    next_s.secondPend = 1'b0;
                end
                if (slotEnd) begin
                    // one key per slot, the whole matrix per scan cycle
                    next_s.pos      = s.pos + 7'h01;
                    next_s.colDrive = colStrobe(s.pos + 7'h01);
                    memWe           = 1'b1;
                    memData         = entry;
                    // code is the matrix position, never the keycap
                    next_s.pushData = {1'b0, s.pos};
                    case (entry.st)
                        KSE_K_IDLE: begin
                            if (hit) begin
                                memData.st  = KSE_K_DEB;
                                memData.cnt = 7'h00;
                            end
                        end
                        KSE_K_DEB: begin
                            if (hit) begin
                                memData.st       = KSE_K_DOWN;
                                memData.cnt      = 7'h00;
                                next_s.pushValid = 1'b1;
                                next_s.secondPend = isNum;
                            end else begin
                                memData.st = KSE_K_IDLE;
                            end
                        end
                        KSE_K_DOWN: begin
                            if (entry.cnt < KSE_REPEAT_DELAY) begin
                                memData.cnt = cntInc;
                            end
                            // bounce before the recheck point is ignored
                            if (entry.cnt < KSE_RECHECK_SCANS - 7'h01) begin
                                memData.st = KSE_K_DOWN;
                            end else if (!hit) begin
                                memData.st = KSE_K_RDEB;
                            end else if (cntInc == KSE_REPEAT_DELAY && !isNum) begin
                                memData.st       = KSE_K_RPT;
                                memData.cnt      = 7'h00;
                                next_s.pushValid = 1'b1;
                            end
                        end
                        KSE_K_RPT: begin
                            if (!hit) begin
                                memData.st = KSE_K_RDEB;
                            end else if (cntInc == KSE_REPEAT_PERIOD) begin
                                memData.cnt      = 7'h00;
                                next_s.pushValid = 1'b1;
                            end else begin
                                memData.cnt = cntInc;
                            end
                        end
                        KSE_K_RDEB: begin
                            if (!hit) begin
                                memData.st       = KSE_K_IDLE;
                                memData.cnt      = 7'h00;
                                // numeric lock sent its break at press
                                next_s.pushValid = !isNum;
                                next_s.pushData  = KSE_BREAK_MASK | {1'b0, s.pos};
                            end else begin
                                memData.st = KSE_K_DOWN;
                            end
                        end
                        default: begin
                            memData = '0;
                        end
                    endcase
                end
            end
            default: begin
                next_s.phase = KSE_P_INIT;
            end
        endcase

        // host side: one code stands until acknowledged
        if (ackWrite && s.latchFull) begin
            next_s.latchFull = 1'b0;
            next_s.irq       = 1'b0;
        end
        if (!s.latchFull && fifoRdValid) begin
            next_s.codeLatch = fifoRdData;
            next_s.latchFull = 1'b1;
            next_s.irq       = 1'b1;
        end
        if (ioWr && ioAddr == KSE_ADDR_PORT_B) begin
            next_s.portB = ioWrData;
        end
        if (ioRd) begin
            if (ioAddr == KSE_ADDR_KEY_CODE) begin
                // bit 7 low selects the code, high the board switches
                next_s.rdData = s.portB[KSE_PORTB_ACK_BIT] ? s.swStable
                                                           : s.codeLatch;
            end else if (ioAddr == KSE_ADDR_PORT_B) begin
                next_s.rdData = s.portB;
            end else begin
                next_s.rdData = KSE_UNMAPPED_READ;
            end
        end
        next_s.ledNum  = 1'b0;
        next_s.ledCaps = 1'b0;
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            s          <= '0;
            s.phase    <= KSE_P_INIT;
            s.portB    <= KSE_PORTB_RESET;
            s.colDrive <= 16'h0001;
            s.linkS1   <= 1'b1;
            s.linkS2   <= 1'b1;
            s.linkS3   <= 1'b1;
            s.linkLevel <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (memWe) begin
            keyMem[s.pos] <= memData;
        end
    end

    // =========================================================
    // type-ahead buffer
    kse_fifo u_fifo (
        .sys_clk (sys_clk),
        .reset   (reset),
        .wrValid (s.pushValid),
        .wrData  (s.pushData),
        .wrReady (),
        .rdValid (fifoRdValid),
        .rdData  (fifoRdData),
        .rdReady (!s.latchFull)
    );

    assign colDrive    = s.colDrive;
    assign ioRdData    = s.rdData;
    assign portBOut    = s.portB;
    assign keyIrq1     = s.irq;
    assign numLockLed  = s.ledNum;
    assign capsLockLed = s.ledCaps;

    // =========================================================
    // checks
    a_irq_on_load: assert property (@(posedge sys_clk) disable iff (reset)
        !s.latchFull && fifoRdValid |=> keyIrq1 && s.codeLatch == $past(fifoRdData))
        else $error("loaded code did not raise the interrupt");
    a_ack_clears_irq: assert property (@(posedge sys_clk) disable iff (reset)
        ackWrite && s.latchFull |=> !keyIrq1 && portBOut[KSE_PORTB_ACK_BIT])
        else $error("acknowledge did not clear the pending code");
    a_hold_until_ack: assert property (@(posedge sys_clk) disable iff (reset)
        s.latchFull && !ackWrite |=> s.latchFull && $stable(s.codeLatch) && keyIrq1)
        else $error("pending code replaced before acknowledge");
    a_code_port_read: assert property (@(posedge sys_clk) disable iff (reset)
        ioRd && ioAddr == KSE_ADDR_KEY_CODE && !portBOut[KSE_PORTB_ACK_BIT]
        |=> ioRdData == $past(s.codeLatch))
        else $error("code port did not return the held code");
    a_numeric_lock_key_pair: assert property (@(posedge sys_clk) disable iff (reset)
        s.pushValid && s.pushData == KSE_CODE_NUM_MAKE
        |=> s.pushValid && s.pushData == KSE_CODE_NUM_BREAK ##1 !s.pushValid)
        else $error("numeric lock press did not send both codes");
    a_break_code: assert property (@(posedge sys_clk) disable iff (reset)
        slotEnd && entry.st == KSE_K_RDEB && !hit && !isNum
        |=> s.pushValid && s.pushData == (KSE_BREAK_MASK | {1'b0, $past(s.pos)}))
        else $error("release did not send the position with bit 7 set");
    a_no_num_repeat: assert property (@(posedge sys_clk) disable iff (reset)
        slotEnd && isNum |-> !(memWe && memData.st == KSE_K_RPT))
        else $error("numeric lock key entered repeat");
    a_repeat_period: assert property (@(posedge sys_clk) disable iff (reset)
        slotEnd && entry.st == KSE_K_RPT && hit && entry.cnt == 7'h07
        |=> s.pushValid && s.pushData[7] == 1'b0)
        else $error("repeat code missing on the eighth scan");
    a_slot_advance: assert property (@(posedge sys_clk) disable iff (reset)
        slotEnd |=> s.pos == $past(s.pos) + 7'h01 && s.slotCnt == 13'h0000)
        else $error("scan did not advance to the next key");
    a_leds_off: assert property (@(posedge sys_clk) disable iff (reset)
        $fell(reset) |-> !numLockLed && !capsLockLed)
        else $error("lock indicators lit after reset");
endmodule // kse_top

// [hdl/kse_pkg.sv]
// constants, types and timing figures of the keyboard scan encoder
// Functional notes
// - thirty-two entry FIFO keeps codes in order
// - scan every 8 ms, repeat after 96 scans
// - repeated make code every eight scans
// - numeric lock key never auto-repeats
// - press and release debounced one scan
// - pressed key checked again eight scans later
// - code names the key position only
// - make has bit 7 clear, break set
// - numeric lock sends 45H, C5H on press
// - lock indicator LEDs off after reset
// - arriving code raises interrupt request one
// - setting bit 7 acknowledges, selects switches
// - self-test, then AAH after 32 ms low
package kse_pkg;
    // =========================================================
    // timing
    localparam int unsigned KSE_CLK_HZ          = 100_000_000;
    localparam int unsigned KSE_SCAN_MS         = 8;
    localparam int unsigned KSE_NUM_KEYS        = 128;
    localparam int unsigned KSE_SCAN_CYCLES     = KSE_CLK_HZ / 1000 * KSE_SCAN_MS;
    localparam int unsigned KSE_SLOT_CYCLES     = KSE_SCAN_CYCLES / KSE_NUM_KEYS;
    localparam int unsigned KSE_LINK_LOW_MS     = 32;
    // "longer than" the figure: one cycle past it
    localparam int unsigned KSE_LINK_LOW_CYCLES = KSE_CLK_HZ / 1000 * KSE_LINK_LOW_MS + 1;
    localparam logic [6:0]  KSE_REPEAT_DELAY    = 7'h60;
    localparam logic [6:0]  KSE_REPEAT_PERIOD   = 7'h08;
    localparam logic [6:0]  KSE_RECHECK_SCANS   = 7'h08;
    // =========================================================
    // buffer
    localparam int unsigned KSE_CODE_W          = 8;
    localparam int unsigned KSE_FIFO_DEPTH      = 32;
    localparam int unsigned KSE_FIFO_PTR_W      = 5;
    // =========================================================
    // host ports and codes
    localparam logic [7:0]  KSE_ADDR_KEY_CODE   = 8'h60;
    localparam logic [7:0]  KSE_ADDR_PORT_B     = 8'h61;
    localparam int unsigned KSE_PORTB_ACK_BIT   = 7;
    localparam logic [7:0]  KSE_PORTB_RESET     = 8'h00;
    localparam logic [7:0]  KSE_UNMAPPED_READ   = 8'h00;
    localparam logic [7:0]  KSE_CODE_NUM_MAKE   = 8'h45;
    localparam logic [7:0]  KSE_CODE_NUM_BREAK  = 8'hC5;
    localparam logic [7:0]  KSE_CODE_SELFTEST   = 8'hAA;
    localparam logic [7:0]  KSE_BREAK_MASK      = 8'h80;
    // =========================================================
    // types
    typedef enum logic [2:0] {
        KSE_K_IDLE = 3'b000,
        KSE_K_DEB  = 3'b001,
        KSE_K_DOWN = 3'b011,
        KSE_K_RPT  = 3'b010,
        KSE_K_RDEB = 3'b110
    } kse_key_state_t;
    typedef struct packed {
        kse_key_state_t st;
        logic [6:0]     cnt;
    } kse_key_t;
    typedef enum logic [1:0] {
        KSE_P_INIT = 2'b00,
        KSE_P_LINK = 2'b01,
        KSE_P_SCAN = 2'b11
    } kse_phase_t;
endpackage

// [hdl/kse_fifo.sv]
// type-ahead code buffer of the keyboard scan encoder
`timescale 1ns/1ps
module kse_fifo (
    input  wire logic                          sys_clk,
    input  wire logic                          reset,
    input  wire logic                          wrValid,
    input  wire logic [kse_pkg::KSE_CODE_W-1:0] wrData,
    output logic                               wrReady,
    output logic                               rdValid,
    output logic [kse_pkg::KSE_CODE_W-1:0]      rdData,
    input  wire logic                          rdReady
);
    import kse_pkg::*;
    typedef struct packed {
        logic [KSE_FIFO_PTR_W:0] wrPtr;
        logic [KSE_FIFO_PTR_W:0] rdPtr;
    } kse_fifo_state_t;
    kse_fifo_state_t                s;
    kse_fifo_state_t                next_s;
    logic [KSE_CODE_W-1:0]          mem [KSE_FIFO_DEPTH];
    logic                           full;
    logic                           empty;

    assign full    = (s.wrPtr[KSE_FIFO_PTR_W-1:0] == s.rdPtr[KSE_FIFO_PTR_W-1:0])
                     && (s.wrPtr[KSE_FIFO_PTR_W] != s.rdPtr[KSE_FIFO_PTR_W]);
    assign empty   = s.wrPtr == s.rdPtr;
    assign wrReady = !full;
    assign rdValid = !empty;
    assign rdData  = mem[s.rdPtr[KSE_FIFO_PTR_W-1:0]];

    always_comb begin
        next_s = s;
        // a full buffer keeps the older codes, the new one is lost
        if (wrValid && !full) begin
            next_s.wrPtr = s.wrPtr + (KSE_FIFO_PTR_W+1)'(1);
        end
        if (rdReady && !empty) begin
            next_s.rdPtr = s.rdPtr + (KSE_FIFO_PTR_W+1)'(1);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (wrValid && !full) begin
            mem[s.wrPtr[KSE_FIFO_PTR_W-1:0]] <= wrData;
        end
    end

    a_fifo_full_drop: assert property (@(posedge sys_clk) disable iff (reset)
        full && !rdReady |=> $stable(s.wrPtr) && full)
        else $error("write into a full buffer moved the write pointer");
    a_fifo_depth_bound: assert property (@(posedge sys_clk) disable iff (reset)
        (s.wrPtr - s.rdPtr) <= (KSE_FIFO_PTR_W+1)'(KSE_FIFO_DEPTH))
        else $error("buffer holds more than its depth");
endmodule // kse_fifo

// [verification/kse_keymat.sv]
// key matrix model: closed keys show on their row while their column is strobed
`timescale 1ns/1ps
module kse_keymat (
    input  wire logic [15:0]  colDrive,
    input  wire logic [127:0] pressed,
    output logic      [7:0]   rowSense
);
    // =========================================================
    // matrix
    // open keys read low, so a released row never shows a stale level
    always_comb begin
        rowSense = 8'h00;
        for (int c = 0; c < 16; c++) begin
            if (colDrive[c]) begin
                rowSense = rowSense | pressed[c*8 +: 8];
            end
        end
    end
endmodule // kse_keymat

// [verification/keyboard_scan_encoder_tb.sv]
// testbench of the keyboard scan encoder: host port tasks and key scenarios
`timescale 1ns/1ps
module keyboard_scan_encoder_tb;
    import kse_pkg::*;
    // rows settle four cycles after a column change, so a slot needs five
    localparam int SLOT = 5;
    localparam int SCAN = SLOT * 128;
    logic         sys_clk     = 1'b0;
    logic         reset       = 1'b1;
    logic         linkClk     = 1'b1;
    logic         linkRun     = 1'b0;
    logic         linkLow     = 1'b0;
    logic [127:0] pressed     = '0;
    logic [7:0]   ioAddr      = 8'h00;
    logic         ioRd        = 1'b0;
    logic         ioWr        = 1'b0;
    logic [7:0]   ioWrData    = 8'h00;
    logic [7:0]   boardSwitch = 8'h5A;
    logic [7:0]   rowSense;
    logic [15:0]  colDrive;
    logic [7:0]   ioRdData;
    logic [7:0]   portBOut;
    logic         keyIrq1;
    logic         numLockLed;
    logic         capsLockLed;
    int           cyc         = 0;
    int           irqCyc      = 0;
    int           errors      = 0;
    int           nChecks     = 0;

    always #5 sys_clk = ~sys_clk;
    // link line held for the startup wait, free running afterwards
    always #40 linkClk = linkRun ? ~linkClk : !linkLow;
    always @(posedge sys_clk) cyc <= cyc + 1;

    kse_top #(.SLOT_CYCLES(SLOT), .LINK_LOW_CYCLES(20)) u_dut (
        .sys_clk(sys_clk), .reset(reset), .rowSense(rowSense), .colDrive(colDrive),
        .linkClk(linkClk), .ioAddr(ioAddr), .ioRd(ioRd), .ioWr(ioWr),
        .ioWrData(ioWrData), .ioRdData(ioRdData), .boardSwitch(boardSwitch),
        .portBOut(portBOut), .keyIrq1(keyIrq1), .numLockLed(numLockLed),
        .capsLockLed(capsLockLed)
    );
    kse_keymat u_keys (.colDrive(colDrive), .pressed(pressed), .rowSense(rowSense));

    // =========================================================
    // host port tasks
    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        nChecks++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic ioWrite(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        ioAddr <= a;
        ioWrData <= d;
        ioWr <= 1'b1;
        @(posedge sys_clk);
        ioWr <= 1'b0;
    endtask

    task automatic ioRead(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        ioAddr <= a;
        ioRd <= 1'b1;
        @(posedge sys_clk);
        ioRd <= 1'b0;
        @(posedge sys_clk);
        #1;
        d = ioRdData;
    endtask

    task automatic waitIrq(input int limit, output logic seen);
        seen = 1'b0;
        for (int i = 0; i < limit && !seen; i++) begin
            @(posedge sys_clk);
            #1;
            seen = (keyIrq1 === 1'b1);
        end
        irqCyc = cyc;
    endtask

    task automatic quiet(input int limit);
        logic seen;
        waitIrq(limit, seen);
        check({7'h00, seen}, 8'h00, "unexpected code");
    endtask

    task automatic getCode(input logic [7:0] exp, input int limit);
        logic       seen;
        logic [7:0] d;
        waitIrq(limit, seen);
        check({7'h00, seen}, 8'h01, "no interrupt");
        ioWrite(KSE_ADDR_PORT_B, 8'h00);
        ioRead(KSE_ADDR_KEY_CODE, d);
        check(d, exp, "key code");
        ioWrite(KSE_ADDR_PORT_B, 8'h80);
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", nChecks, errors);
        if (errors == 0 && nChecks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // =========================================================
    // tests
    initial begin
        #1_000_000;
        errors++;
        $display("BAD %0t run hung", $time);
        test_done();
    end

    initial begin
        logic [7:0] d;
        int         t0;
        int         t1;
        repeat (20) @(posedge sys_clk);
        reset <= 1'b0;
        ioRead(KSE_ADDR_PORT_B, d);
        check(d, 8'h00, "control port reset");
        check({6'h00, numLockLed, capsLockLed}, 8'h00, "lock leds");
        ioRead(8'h62, d);
        check(d, 8'h00, "unmapped read");
        quiet(300);
        linkLow <= 1'b1;
        t0 = cyc;
        getCode(8'hAA, 2000);
        check({7'h00, (irqCyc - t0) > 20}, 8'h01, "startup too early");
        ioRead(KSE_ADDR_KEY_CODE, d);
        check(d, 8'h5A, "switch status");
        check(portBOut, 8'h80, "control port");
        quiet(20);
        linkRun = 1'b1;
        $display("test startup done");

        pressed[8'h21] <= 1'b1;
        repeat (300) @(posedge sys_clk);
        pressed[8'h21] <= 1'b0;
        quiet(3 * SCAN);
        $display("test debounce done");

        // one key at a time, so the code order does not hang on the scan phase
        pressed[8'h10] <= 1'b1;
        getCode(8'h10, 3 * SCAN);
        t0 = irqCyc;
        pressed[8'h45] <= 1'b1;
        getCode(KSE_CODE_NUM_MAKE, 3 * SCAN);
        getCode(KSE_CODE_NUM_BREAK, 64);
        getCode(8'h10, 100 * SCAN);
        t1 = irqCyc;
        check({7'h00, (t1 - t0) >= 94 * SCAN && (t1 - t0) <= 97 * SCAN}, 8'h01, "delay");
        getCode(8'h10, 9 * SCAN);
        check({7'h00, (irqCyc - t1) == 8 * SCAN}, 8'h01, "repeat period");
        pressed[8'h10] <= 1'b0;
        pressed[8'h45] <= 1'b0;
        getCode(8'h90, 3 * SCAN);
        quiet(6 * SCAN);
        $display("test repeat done");

        // forty makes in one scan: latch plus 32 entries survive
        // press past the last of them, read only once all are queued
        wait (colDrive[5]);
        @(posedge sys_clk);
        pressed[39:0] <= '1;
        repeat (3 * SCAN) @(posedge sys_clk);
        for (int i = 0; i < 33; i++) begin
            getCode(8'(i), 3 * SCAN);
        end
        quiet(2 * SCAN);
        repeat (6 * SCAN) @(posedge sys_clk);
        wait (colDrive[5]);
        @(posedge sys_clk);
        pressed[39:0] <= '0;
        repeat (3 * SCAN) @(posedge sys_clk);
        for (int i = 0; i < 33; i++) begin
            getCode(8'h80 | 8'(i), 3 * SCAN);
        end
        quiet(2 * SCAN);
        $display("test buffer done");
        test_done();
    end
endmodule // keyboard_scan_encoder_tb
